// File: logic/dfs_consts.vh
// constants for the drive fault supervisor: register map, fault codes,
// field positions and timing; assumes inclusion by its bare name.
//
// Summary of operation
// [RULE_01] External trip request latches alarm-stop, inhibits output, relay, external code.
// [RULE_02] Estimated switch transistor temperature above threshold trips with overload code.
// [RULE_03] Thermal select 1 applies general-purpose motor characteristic at all frequencies.
// [RULE_04] Thermal select 2 applies inverter-duty motor characteristic at all frequencies.
// [RULE_05] Thermal trip level and time constant come from their own settings.
// [RULE_06] Second motor selected: use second motor's select, level, time constant.
// [RULE_07] Sensor overtemperature with sensor protection on inhibits output, sensor code.
// [RULE_08] Early warning output when thermal estimate reaches preset level below trip.
// [RULE_09] Over-limit current while accelerating or steady limits current, no alarm.
// [RULE_10] Any alarm stop closes the alarm relay contact.
// [RULE_11] Alarm-stop clears only by keypad reset key or alarm reset input.
// [RULE_12] Keep history of the last 4 alarms with detail data, readable.
// [RULE_13] Memory check failure after power-on or write stops with memory code.
// [RULE_14] Keypad link error while keypad operated stops with keypad-link code.
// [RULE_15] Processor or support logic error stops with processor code.
// [RULE_16] Alarm-stop stays latched with code held until a valid reset.
`ifndef DFS_CONSTS_VH
`define DFS_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define DFS_REG_CTRL 8'h00
`define DFS_REG_THRESH 8'h04
`define DFS_REG_THERM1 8'h08
`define DFS_REG_THERM2 8'h0C
`define DFS_REG_STATUS 8'h10
`define DFS_REG_FAULT 8'h14
`define DFS_REG_IRQ_STAT 8'h18
`define DFS_REG_IRQ_EN 8'h1C
`define DFS_REG_IRQ_CLR 8'h20
`define DFS_REG_HIST0 8'h24
`define DFS_REG_HIST_LAST 8'h30
`define DFS_REG_EST 8'h34

// ****************************************
// fault codes
// ****************************************
`define DFS_CODE_NONE 4'h0
`define DFS_CODE_OVERLOAD 4'h1
`define DFS_CODE_EXT 4'h2
`define DFS_CODE_THERM1 4'h3
`define DFS_CODE_THERM2 4'h4
`define DFS_CODE_SENSOR 4'h5
`define DFS_CODE_MEM 4'h6
`define DFS_CODE_KEYPAD 4'h7
`define DFS_CODE_CPU 4'h8

// ****************************************
// control register fields
// ****************************************
`define DFS_CTRL_SENSOR_EN 0
`define DFS_CTRL_KEYPAD_OP 1
`define DFS_CTRL_SOFT_RST 2
`define DFS_THERM_SEL_LO 0
`define DFS_THERM_SEL_HI 1
`define DFS_THERM_LVL_LO 8
`define DFS_THERM_LVL_HI 23
`define DFS_THERM_TC_LO 24
`define DFS_THERM_TC_HI 31
`define DFS_SEL_GENERAL 2'h1
`define DFS_SEL_INVDUTY 2'h2

// ****************************************
// interrupt bits
// ****************************************
`define DFS_IRQ_TRIP 0
`define DFS_IRQ_WARN 1
`define DFS_IRQ_LIMIT 2
`define DFS_IRQ_W 3

// ****************************************
// timing: thermal estimate tick
// ****************************************
`define DFS_TICK_NS 1000
`define DFS_CLK_NS 8
`define DFS_TICK_CYC (`DFS_TICK_NS / `DFS_CLK_NS)
`define DFS_WARN_SHIFT 3
`define DFS_DECAY_SHIFT 4

`endif

// File: logic/dfs_supervisor.v
// drive fault supervisor: latches trip causes into an alarm-stop state
// with output inhibit, relay, fault code, history and interrupts.
// assumes one 125 MHz clock, synchronous inputs, an AXI4-Lite master.
`timescale 1ns/1ns
`default_nettype none
`include "dfs_consts.vh"

module dfs_supervisor #(
   parameter CUR_W = 16,
   parameter HIST_N = 4
) (
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // power stage and sensor side
   input wire external_trip_request,
   input wire [CUR_W-1:0] output_current,
   input wire [CUR_W-1:0] switch_temp_est,
   input wire [CUR_W-1:0] current_limit_level,
   input wire accel_or_steady,
   input wire sensor_overtemp,
   input wire motor2_select,
   input wire mem_check_fail,
   input wire keypad_link_error,
   input wire cpu_error,
   // operator side
   input wire keypad_reset_key,
   input wire alarm_reset_in,
   output reg output_inhibit,
   output reg alarm_relay,
   output reg [3:0] fault_code,
   output reg early_warning,
   output reg current_limit,
   output wire irq
);

   // ****************************************
   // register state
   // ****************************************
   reg [31:0] ctrl_q;
   reg [CUR_W-1:0] thresh_q;
   reg [31:0] therm1_q;
   reg [31:0] therm2_q;
   reg [`DFS_IRQ_W-1:0] irq_stat_q;
   reg [`DFS_IRQ_W-1:0] irq_en_q;
   reg [31:0] hist_q [0:HIST_N-1];
   reg [31:0] est_q;
   reg [15:0] tick_q;
   reg [7:0] tc_cnt_q;
   reg aw_got_q;
   reg w_got_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   integer i;

   // decode a register byte offset to its word number
   function [3:0] dfs_word;
      input [7:0] addr;
      begin
         dfs_word = addr[5:2];
      end
   endfunction

   // ****************************************
   // active motor thermal settings
   // ****************************************
   wire [31:0] therm_act = motor2_select ? therm2_q : therm1_q; // [RULE_06]
   wire [1:0] therm_sel = therm_act[`DFS_THERM_SEL_HI:`DFS_THERM_SEL_LO];
   wire [15:0] therm_lvl = therm_act[`DFS_THERM_LVL_HI:`DFS_THERM_LVL_LO];
   wire [7:0] therm_tc = therm_act[`DFS_THERM_TC_HI:`DFS_THERM_TC_LO];
   wire [31:0] lvl_ext = {16'h0000, therm_lvl};
   // general-purpose and inverter-duty models share the integrator here
   wire therm_on = (therm_sel == `DFS_SEL_GENERAL) ||
      (therm_sel == `DFS_SEL_INVDUTY); // [RULE_03] [RULE_04]
   wire [31:0] cur_ext = {{(32-CUR_W){1'b0}}, output_current};
   wire therm_trip = therm_on && (est_q >= lvl_ext); // [RULE_05]
   wire warn_now = therm_on &&
      (est_q >= (lvl_ext - (lvl_ext >> `DFS_WARN_SHIFT))); // [RULE_08]

   // ****************************************
   // trip cause priority
   // ****************************************
   reg [3:0] cause;
   always @* begin
      cause = `DFS_CODE_NONE;
      if (cpu_error)
         cause = `DFS_CODE_CPU; // [RULE_15]
      else if (mem_check_fail)
         cause = `DFS_CODE_MEM; // [RULE_13]
      else if (keypad_link_error && ctrl_q[`DFS_CTRL_KEYPAD_OP])
         cause = `DFS_CODE_KEYPAD; // [RULE_14]
      else if (switch_temp_est > thresh_q)
         cause = `DFS_CODE_OVERLOAD; // [RULE_02]
      else if (external_trip_request)
         cause = `DFS_CODE_EXT; // [RULE_01]
      else if (sensor_overtemp && ctrl_q[`DFS_CTRL_SENSOR_EN])
         cause = `DFS_CODE_SENSOR; // [RULE_07]
      else if (therm_trip)
         cause = motor2_select ? `DFS_CODE_THERM2 : `DFS_CODE_THERM1;
   end

   wire reset_evt = keypad_reset_key || alarm_reset_in; // [RULE_11]
   wire trip_new = (cause != `DFS_CODE_NONE) && !alarm_relay;
   wire limit_now = accel_or_steady && !alarm_relay &&
      (output_current > current_limit_level); // [RULE_09]

   // ****************************************
   // alarm-stop latch and history
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         output_inhibit <= 1'b0;
         alarm_relay <= 1'b0;
         fault_code <= `DFS_CODE_NONE;
         for (i = 0; i < HIST_N; i = i + 1)
            hist_q[i] <= 32'h00000000;
      end else if (alarm_relay) begin
         // held even if the cause clears
         if (reset_evt && cause == `DFS_CODE_NONE) begin // [RULE_16]
            output_inhibit <= 1'b0;
            alarm_relay <= 1'b0;
            fault_code <= `DFS_CODE_NONE; // [RULE_11]
         end
      end else if (trip_new) begin
         output_inhibit <= 1'b1;
         alarm_relay <= 1'b1; // [RULE_10]
         fault_code <= cause;
         for (i = HIST_N - 1; i > 0; i = i - 1)
            hist_q[i] <= hist_q[i-1];
         hist_q[0] <= {cause, 4'h0, output_current[15:0],
            est_q[7:0]}; // [RULE_12]
      end
   end

   // ****************************************
   // thermal estimate and warnings
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         est_q <= 32'h00000000;
         tick_q <= 16'h0000;
         tc_cnt_q <= 8'h00;
         early_warning <= 1'b0;
         current_limit <= 1'b0;
      end else begin
         early_warning <= warn_now; // [RULE_08]
         current_limit <= limit_now; // [RULE_09]
         if (tick_q == `DFS_TICK_CYC - 1) begin
            tick_q <= 16'h0000;
            if (tc_cnt_q >= therm_tc) begin
               tc_cnt_q <= 8'h00;
               // heat in by current, decay by 1/16
               est_q <= est_q - (est_q >> `DFS_DECAY_SHIFT) +
                  (cur_ext >> `DFS_DECAY_SHIFT); // [RULE_05]
            end else begin
               tc_cnt_q <= tc_cnt_q + 8'h01;
            end
         end else begin
            tick_q <= tick_q + 16'h0001;
         end
      end
   end

   // ****************************************
   // interrupt status, enable, clear
   // ****************************************
   wire [`DFS_IRQ_W-1:0] irq_evt = {limit_now && !current_limit,
      warn_now && !early_warning, trip_new};
   wire wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
   wire [3:0] wr_word = dfs_word(awaddr_q);
   wire [`DFS_IRQ_W-1:0] irq_clr = (wr_fire &&
      wr_word == dfs_word(`DFS_REG_IRQ_CLR)) ?
      wdata_q[`DFS_IRQ_W-1:0] : {`DFS_IRQ_W{1'b0}};
   assign irq = |(irq_stat_q & irq_en_q);

   // set wins over clear
   always @(posedge aclk) begin
      if (!aresetn)
         irq_stat_q <= {`DFS_IRQ_W{1'b0}};
      else
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
   end

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
   assign s_axi_wready = !w_got_q && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         ctrl_q <= 32'h00000000;
         thresh_q <= {CUR_W{1'b1}};
         therm1_q <= 32'h00000000;
         therm2_q <= 32'h00000000;
         irq_en_q <= {`DFS_IRQ_W{1'b0}};
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (wr_word)
               dfs_word(`DFS_REG_CTRL): ctrl_q <= wdata_q;
               dfs_word(`DFS_REG_THRESH): thresh_q <= wdata_q[CUR_W-1:0];
               dfs_word(`DFS_REG_THERM1): therm1_q <= wdata_q;
               dfs_word(`DFS_REG_THERM2): therm2_q <= wdata_q;
               dfs_word(`DFS_REG_IRQ_EN):
                  irq_en_q <= wdata_q[`DFS_IRQ_W-1:0];
               dfs_word(`DFS_REG_IRQ_CLR): ;
               default: s_axi_bresp <= 2'h2;
            endcase
         end
      end
   end

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   assign s_axi_arready = !s_axi_rvalid;
   wire [3:0] rd_word = dfs_word(s_axi_araddr);
   wire [3:0] hist_idx = rd_word - dfs_word(`DFS_REG_HIST0);

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         if (rd_word >= dfs_word(`DFS_REG_HIST0) &&
            rd_word <= dfs_word(`DFS_REG_HIST_LAST))
            s_axi_rdata <= hist_q[hist_idx[1:0]]; // [RULE_12]
         else begin
            case (rd_word)
               dfs_word(`DFS_REG_CTRL): s_axi_rdata <= ctrl_q;
               dfs_word(`DFS_REG_THRESH):
                  s_axi_rdata <= {{(32-CUR_W){1'b0}}, thresh_q};
               dfs_word(`DFS_REG_THERM1): s_axi_rdata <= therm1_q;
               dfs_word(`DFS_REG_THERM2): s_axi_rdata <= therm2_q;
               dfs_word(`DFS_REG_STATUS):
                  s_axi_rdata <= {27'h0, current_limit,
                     early_warning, alarm_relay, output_inhibit, irq};
               dfs_word(`DFS_REG_FAULT):
                  s_axi_rdata <= {28'h0000000, fault_code};
               dfs_word(`DFS_REG_IRQ_STAT):
                  s_axi_rdata <= {29'h0, irq_stat_q};
               dfs_word(`DFS_REG_IRQ_EN):
                  s_axi_rdata <= {29'h0, irq_en_q};
               dfs_word(`DFS_REG_EST): s_axi_rdata <= est_q;
               dfs_word(`DFS_REG_IRQ_CLR): s_axi_rdata <= 32'h00000000;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // dfs_supervisor
`default_nettype wire

// File: verif/dfs_checker.sv
// checker on the fault supervisor ports
// assumes a bind onto dfs_supervisor with one clock
`timescale 1ns/1ns
`default_nettype none
module dfs_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic external_trip_request,
   input wire logic cpu_error,
   input wire logic mem_check_fail,
   input wire logic keypad_reset_key,
   input wire logic alarm_reset_in,
   input wire logic output_inhibit,
   input wire logic alarm_relay,
   input wire logic [3:0] fault_code,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_arready
);
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire rst_ev = keypad_reset_key || alarm_reset_in;
   wire hi_cause = cpu_error || mem_check_fail;
   chk_ext_trip:
   assert property (!output_inhibit && external_trip_request && !hi_cause
      |=> output_inhibit && fault_code == 4'h2) else $error("ext trip");
   chk_cpu_trip:
   assert property (!output_inhibit && cpu_error
      |=> output_inhibit && fault_code == 4'h8) else $error("cpu trip");
   chk_mem_trip:
   assert property (!output_inhibit && mem_check_fail && !cpu_error
      |=> fault_code == 4'h6) else $error("mem trip");
   chk_relay_follow:
   assert property (alarm_relay == output_inhibit) else $error("relay");
   chk_latch_hold:
   assert property (output_inhibit && !rst_ev
      |=> output_inhibit && $stable(fault_code)) else $error("latch");
   chk_reset_clear:
   assert property (output_inhibit && rst_ev && !hi_cause
      && !external_trip_request |=> !output_inhibit) else $error("clear");
   chk_bresp_hold:
   assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp");
   chk_read_block:
   assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
endmodule // dfs_checker

bind dfs_supervisor dfs_checker u_chk (
   .aclk(aclk),
   .aresetn(aresetn),
   .external_trip_request(external_trip_request),
   .cpu_error(cpu_error),
   .mem_check_fail(mem_check_fail),
   .keypad_reset_key(keypad_reset_key),
   .alarm_reset_in(alarm_reset_in),
   .output_inhibit(output_inhibit),
   .alarm_relay(alarm_relay),
   .fault_code(fault_code),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_arready(s_axi_arready)
);
`default_nettype wire

// File: verif/dfs_plant.sv
// model of power stage and keypad: registered fault and reset levels
// assumes commands set by the bench just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module dfs_plant (
   input wire logic aclk,
   input wire logic [5:0] cmd,
   output logic external_trip_request,
   output logic cpu_error,
   output logic mem_check_fail,
   output logic alarm_reset_in,
   output logic keypad_reset_key,
   output logic accel_or_steady
);
   // levels follow the command one edge later
   always @(posedge aclk) begin
      external_trip_request <= cmd[2];
      cpu_error <= cmd[1];
      mem_check_fail <= cmd[0];
      alarm_reset_in <= cmd[3];
      keypad_reset_key <= cmd[4];
      accel_or_steady <= cmd[5];
   end
endmodule // dfs_plant
`default_nettype wire

// File: verif/dfs_supervisor_tb.sv
// testbench for the fault supervisor
// assumes dfs_consts.vh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "dfs_consts.vh"
module dfs_supervisor_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [5:0] cmd = 6'h00;
   logic [15:0] cur = 16'h0000;
   logic [15:0] temp = 16'h0000;
   logic sens = 1'b0;
   logic klink = 1'b0;
   logic m2 = 1'b0;
   logic [31:0] cap_d;
   logic [1:0] cap_r;
   logic ok;
   integer bad_count = 0;
   integer comparisons = 0;
   wire awready, wready, bvalid, arready, rvalid, inh, relay, climit, irq;
   wire ext, cpu, mem, rsta, rstk, accel, warn;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] fcode;
   // ****************************************
   // structure
   // ****************************************
   always #4 aclk = ~aclk;
   dfs_plant u_plant (.aclk(aclk), .cmd(cmd), .external_trip_request(ext),
      .cpu_error(cpu), .mem_check_fail(mem), .alarm_reset_in(rsta),
      .keypad_reset_key(rstk), .accel_or_steady(accel));
   dfs_supervisor u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .external_trip_request(ext),
      .output_current(cur), .switch_temp_est(temp),
      .current_limit_level(16'h0100), .accel_or_steady(accel),
      .sensor_overtemp(sens), .motor2_select(m2),
      .mem_check_fail(mem), .keypad_link_error(klink), .cpu_error(cpu),
      .keypad_reset_key(rstk), .alarm_reset_in(rsta),
      .output_inhibit(inh), .alarm_relay(relay), .fault_code(fcode),
      .early_warning(warn), .current_limit(climit), .irq(irq));
   // ****************************************
   // helpers
   // ****************************************
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // hold ready while waiting, take payload for the handshake edge
   task fin(input logic rd);
      begin
         ok = 1'b0;
         if (rd) rready <= 1'b1;
         else bready <= 1'b1;
         repeat (50) if (!ok) begin
            @(negedge aclk);
            ok = rd ? rvalid : bvalid;
            cap_d = rdata;
            cap_r = rd ? rresp : bresp;
            @(posedge aclk);
         end
         chk(ok, 1);
         rready <= 1'b0;
         bready <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      logic ta, tw;
      begin
         ta = 1'b0;
         tw = 1'b0;
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         repeat (50) if (!(ta && tw)) begin
            @(negedge aclk);
            ta = ta | awready;
            tw = tw | wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
         end
         fin(1'b0);
      end
   endtask
   task rd(input [7:0] a);
      begin
         ok = 1'b0;
         araddr <= a;
         arvalid <= 1'b1;
         repeat (50) if (!ok) begin
            @(negedge aclk);
            ok = arready;
            @(posedge aclk);
         end
         arvalid <= 1'b0;
         fin(1'b1);
      end
   endtask
   task wi(input logic v);
      begin
         ok = 1'b0;
         repeat (4000) if (!ok) begin
            @(negedge aclk);
            ok = (inh === v);
         end
         chk(inh, v);
         @(posedge aclk);
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task s_regs;
      begin
         rd(`DFS_REG_FAULT);
         chk(cap_d, 0);
         rd(8'hFC);
         chk(cap_r, 2'h2);
         wr(`DFS_REG_IRQ_EN, 1);
         rd(`DFS_REG_IRQ_EN);
         chk(cap_d, 1);
      end
   endtask
   task s_ext;
      begin
         cmd <= 6'h04;
         wi(1'b1);
         chk(fcode, `DFS_CODE_EXT);
         chk(relay, 1);
         cmd <= 6'h00;
         repeat (5) @(posedge aclk);
         chk({inh, fcode}, {1'b1, `DFS_CODE_EXT});
         chk(irq, 1);
         cmd <= 6'h08;
         wi(1'b0);
         cmd <= 6'h00;
         wr(`DFS_REG_IRQ_CLR, 1);
         chk(irq, 0);
      end
   endtask
   task s_cpu_mem;
      begin
         wr(`DFS_REG_IRQ_EN, 0);
         cmd <= 6'h07;
         wi(1'b1);
         chk(fcode, `DFS_CODE_CPU);
         chk(irq, 0);
         cmd <= 6'h10;
         wi(1'b0);
         cmd <= 6'h01;
         wi(1'b1);
         chk(fcode, `DFS_CODE_MEM);
         cmd <= 6'h09;
         repeat (5) @(posedge aclk);
         chk(inh, 1);
         cmd <= 6'h08;
         wi(1'b0);
         cmd <= 6'h00;
         wr(`DFS_REG_IRQ_EN, 1);
         chk(irq, 1);
         rd(`DFS_REG_HIST0);
         chk(cap_d[31:28], `DFS_CODE_MEM);
         rd(`DFS_REG_HIST0 + 8'h04);
         chk(cap_d[31:28], `DFS_CODE_CPU);
         rd(`DFS_REG_HIST0 + 8'h08);
         chk(cap_d[31:28], `DFS_CODE_EXT);
      end
   endtask
   task s_limit;
      begin
         cur <= 16'h0200;
         cmd <= 6'h20;
         repeat (5) @(posedge aclk);
         chk({climit, inh, fcode}, 6'h20);
         cmd <= 6'h00;
         repeat (5) @(posedge aclk);
         chk(climit, 0);
         cur <= 16'h0000;
         rd(`DFS_REG_IRQ_STAT);
         chk(cap_d[`DFS_IRQ_LIMIT], 1);
      end
   endtask
   task s_causes;
      begin
         wr(`DFS_REG_THRESH, 32'h00000100);
         temp <= 16'h0100;
         repeat (5) @(posedge aclk);
         chk(inh, 0);
         temp <= 16'h0101;
         wi(1'b1);
         chk(fcode, `DFS_CODE_OVERLOAD);
         temp <= 16'h0000;
         cmd <= 6'h10;
         wi(1'b0);
         cmd <= 6'h00;
         sens <= 1'b1;
         klink <= 1'b1;
         repeat (5) @(posedge aclk);
         chk(inh, 0);
         wr(`DFS_REG_CTRL, 32'h00000001);
         wi(1'b1);
         chk(fcode, `DFS_CODE_SENSOR);
         sens <= 1'b0;
         cmd <= 6'h10;
         wi(1'b0);
         cmd <= 6'h00;
         wr(`DFS_REG_CTRL, 32'h00000002);
         wi(1'b1);
         chk(fcode, `DFS_CODE_KEYPAD);
         klink <= 1'b0;
         cmd <= 6'h10;
         wi(1'b0);
         cmd <= 6'h00;
         wr(`DFS_REG_CTRL, 32'h00000000);
      end
   endtask
   task s_therm;
      begin
         cur <= 16'h0F00;
         wr(`DFS_REG_THERM1, 32'h000C0001);
         ok = 1'b0;
         repeat (4000) if (!ok) begin
            @(negedge aclk);
            ok = warn;
         end
         chk({warn, inh}, 2'h2);
         wi(1'b1);
         chk(fcode, `DFS_CODE_THERM1);
         wr(`DFS_REG_THERM1, 32'h00000000);
         cmd <= 6'h10;
         wi(1'b0);
         cmd <= 6'h00;
         wr(`DFS_REG_THERM2, 32'h000C0002);
         m2 <= 1'b1;
         wi(1'b1);
         chk(fcode, `DFS_CODE_THERM2);
         wr(`DFS_REG_THERM2, 32'h00000000);
         m2 <= 1'b0;
         cur <= 16'h0000;
         cmd <= 6'h10;
         wi(1'b0);
         cmd <= 6'h00;
      end
   endtask
   task end_sim;
      begin
         if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // ****************************************
   // sequence and watchdog
   // ****************************************
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      s_regs();
      s_ext();
      s_cpu_mem();
      s_limit();
      s_causes();
      s_therm();
      end_sim();
   end
   initial begin
      #100000;
      bad_count = bad_count + 1;
      end_sim();
   end
endmodule // dfs_supervisor_tb
`default_nettype wire
